// ---- rtl/sccu_defs.vh ----
`ifndef SCCU_DEFS_VH
`define SCCU_DEFS_VH

// ----------------------------------------
// opcodes and command types
// ----------------------------------------
`define SCCU_OP_SIGNED 8'h9B
`define SCCU_OP_READBACK 8'h96
`define SCCU_OP_RST_EN 8'h66
`define SCCU_OP_RST 8'h99
`define SCCU_CT_INC 8'h02
`define SCCU_CT_REQ 8'h03

// ----------------------------------------
// whole frame lengths in bytes, opcode and header included
// ----------------------------------------
`define SCCU_LEN_INC 6'd40
`define SCCU_LEN_REQ 6'd48
`define SCCU_LEN_RB 6'd51

// ----------------------------------------
// status bit positions
// ----------------------------------------
`define SCCU_ST_BUSY 0
`define SCCU_ST_SIG 2
`define SCCU_ST_UNINIT 3
`define SCCU_ST_MISM 4
`define SCCU_ST_FATAL 5
`define SCCU_ST_OK 7

// ----------------------------------------
// slots and timing
// ----------------------------------------
`define SCCU_NUM_SLOTS 8'd4
`define SCCU_CLK_MHZ 250
`define SCCU_TRST_US 30
`define SCCU_TRST_CYC (`SCCU_TRST_US * `SCCU_CLK_MHZ)

`endif

// ---- rtl/sccu_sync.v ----
`timescale 1ns/100ps
module sccu_sync #(
    parameter [0:0] RST_VAL = 1'b0
) (
    // clock and reset
    input wire core_clk,
    input wire rstn,
    // async level in, synced level out
    input wire async_in,
    output wire sync_out
);
    reg meta_q;
    reg sync_q;

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule // sccu_sync

// ---- rtl/sccu_shift.v ----
`timescale 1ns/100ps
module sccu_shift (
    // clock and reset
    input wire core_clk,
    input wire rstn,
    // bit strobes
    input wire frame_start,
    input wire sample_en,
    input wire din,
    // byte out
    output reg [7:0] byte_q,
    output reg byte_vld_q
);
    reg [2:0] bit_cnt_q;
    reg [6:0] acc_q;

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            bit_cnt_q <= 3'd0;
            acc_q <= 7'd0;
            byte_q <= 8'h00;
            byte_vld_q <= 1'b0;
        end else begin
            byte_vld_q <= 1'b0;
            if (frame_start) begin
                bit_cnt_q <= 3'd0;
            end else if (sample_en) begin
                // msb first, eight clocks per byte
                acc_q <= {acc_q[5:0], din};
                bit_cnt_q <= bit_cnt_q + 3'd1;
                if (bit_cnt_q == 3'd7) begin
                    byte_q <= {acc_q, din};
                    byte_vld_q <= 1'b1;
                end
            end
        end
    end
endmodule // sccu_shift

// ---- rtl/sccu_top.v ----
`timescale 1ns/100ps
`include "sccu_defs.vh"
module sccu_top #(
    parameter TRST_CYC = `SCCU_TRST_CYC
) (
    // clock and reset
    input wire core_clk,
    input wire rstn,
    // spi pins
    input wire spi_clk,
    input wire spi_cs_n,
    input wire spi_di,
    output reg spi_do_q,
    output wire spi_do_oe,
    // counter and key state from the secure store
    input wire [3:0] slot_ctr_init,
    input wire [3:0] slot_key_loaded,
    input wire [127:0] slot_ctr_flat,
    // hmac engine
    output reg hmac_start_q,
    output reg [1:0] hmac_slot_q,
    output reg [255:0] hmac_msg_q,
    output reg [8:0] hmac_msg_len_q,
    input wire hmac_done,
    input wire [255:0] hmac_digest,
    // counter commit
    output reg ctr_wr_q,
    output reg [1:0] ctr_wr_slot_q,
    output reg [31:0] ctr_wr_val_q,
    input wire ctr_wr_done,
    input wire ctr_wr_fail,
    // status view
    output wire [7:0] status,
    output wire reset_recovery
);
    // ----------------------------------------
    // pin synchronisation and edges
    // ----------------------------------------
    wire clk_s;
    wire cs_s;
    wire di_s;
    reg clk_d_q;
    reg cs_d_q;
    sccu_sync u_sync_clk (.core_clk(core_clk), .rstn(rstn), .async_in(spi_clk), .sync_out(clk_s));
    // select resets to its idle level so no false frame edge follows reset
    sccu_sync #(.RST_VAL(1'b1)) u_sync_cs (.core_clk(core_clk), .rstn(rstn),
        .async_in(spi_cs_n), .sync_out(cs_s));
    sccu_sync u_sync_di (.core_clk(core_clk), .rstn(rstn), .async_in(spi_di), .sync_out(di_s));

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            clk_d_q <= 1'b0;
            cs_d_q <= 1'b1;
        end else begin
            clk_d_q <= clk_s;
            cs_d_q <= cs_s;
        end
    end

    wire active = !cs_s;
    wire frame_start = cs_d_q && !cs_s;
    wire frame_end = !cs_d_q && cs_s;
    wire rise = active && clk_s && !clk_d_q;
    wire fall = active && !clk_s && clk_d_q;

    wire [7:0] rx_byte;
    wire rx_vld;
    sccu_shift u_shift (
        .core_clk(core_clk),
        .rstn(rstn),
        .frame_start(frame_start),
        .sample_en(rise),
        .din(di_s),
        .byte_q(rx_byte),
        .byte_vld_q(rx_vld)
    );

    // ----------------------------------------
    // state
    // ----------------------------------------
    localparam [3:0] S_IDLE = 4'b0001;
    localparam [3:0] S_SIGN = 4'b0010;
    localparam [3:0] S_COMMIT = 4'b0100;
    localparam [3:0] S_RESP = 4'b1000;

    reg [3:0] state_q;
    reg [7:0] st_q;
    reg [5:0] byte_cnt_q;
    reg [7:0] opcode_q;
    reg [7:0] ctype_q;
    reg [7:0] slot_q;
    reg [7:0] rsvd_q;
    reg [31:0] hdata_q;
    reg [95:0] tag_q;
    reg [255:0] sig_q;
    reg rst_armed_q;
    reg [13:0] rec_cnt_q;
    reg cmd_pending_q;
    reg [391:0] rb_q;
    reg rb_valid_q;
    reg [8:0] tx_bit_q;
    reg sreset_q;
    reg tx_en_q;

    wire busy = !state_q[0];
    // only an idle signed frame may load command fields
    wire capture = (opcode_q == `SCCU_OP_SIGNED) && state_q[0];
    assign status = {st_q[7:1], busy};
    assign reset_recovery = rec_cnt_q != 14'd0;
    assign spi_do_oe = tx_en_q && active;

    wire [1:0] slot2 = slot_q[1:0];
    wire [31:0] ctr_cur = slot_ctr_flat[slot2*32 +: 32];

    // ----------------------------------------
    // receive, checks, sequencing
    // ----------------------------------------
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= S_IDLE;
            st_q <= 8'h00;
            byte_cnt_q <= 6'd0;
            opcode_q <= 8'h00;
            ctype_q <= 8'h00;
            slot_q <= 8'h00;
            rsvd_q <= 8'h00;
            hdata_q <= 32'h0000_0000;
            tag_q <= 96'h0;
            sig_q <= 256'h0;
            rst_armed_q <= 1'b0;
            rec_cnt_q <= 14'd0;
            cmd_pending_q <= 1'b0;
            rb_valid_q <= 1'b0;
            hmac_start_q <= 1'b0;
            hmac_slot_q <= 2'd0;
            hmac_msg_q <= 256'h0;
            hmac_msg_len_q <= 9'd0;
            ctr_wr_q <= 1'b0;
            ctr_wr_slot_q <= 2'd0;
            ctr_wr_val_q <= 32'h0000_0000;
            sreset_q <= 1'b0;
        end else if (sreset_q) begin
            state_q <= S_IDLE;
            st_q <= 8'h00;
            rb_valid_q <= 1'b0;
            rst_armed_q <= 1'b0;
            cmd_pending_q <= 1'b0;
            hmac_start_q <= 1'b0;
            ctr_wr_q <= 1'b0;
            sreset_q <= 1'b0;
            rec_cnt_q <= TRST_CYC[13:0];
        end else begin
            hmac_start_q <= 1'b0;
            ctr_wr_q <= 1'b0;
            if (rec_cnt_q != 14'd0) begin
                rec_cnt_q <= rec_cnt_q - 14'd1;
            end
            if (frame_start) begin
                byte_cnt_q <= 6'd0;
            end
            if (rx_vld && rec_cnt_q == 14'd0) begin
                if (byte_cnt_q != 6'h3F) begin
                    byte_cnt_q <= byte_cnt_q + 6'd1;
                end
                // a status read during busy must not disturb the pending command
                case (byte_cnt_q)
                    6'd0: opcode_q <= rx_byte;
                    6'd1: ctype_q <= capture ? rx_byte : ctype_q;
                    6'd2: slot_q <= capture ? rx_byte : slot_q;
                    6'd3: rsvd_q <= capture ? rx_byte : rsvd_q;
                    default: begin
                        if (capture && byte_cnt_q < 6'd8) begin
                            hdata_q <= {hdata_q[23:0], rx_byte};
                        end
                        if (capture && byte_cnt_q < 6'd16) begin
                            tag_q <= {tag_q[87:0], rx_byte};
                        end
                        if (capture) begin
                            sig_q <= {sig_q[247:0], rx_byte};
                        end
                    end
                endcase
                if (byte_cnt_q == 6'd0) begin
                    if (rx_byte == `SCCU_OP_RST && rst_armed_q && !busy) begin
                        sreset_q <= 1'b1;
                    end
                    rst_armed_q <= (rx_byte == `SCCU_OP_RST_EN);
                end
            end
            if (frame_end && rec_cnt_q == 14'd0 && state_q == S_IDLE
                    && opcode_q == `SCCU_OP_SIGNED && byte_cnt_q != 6'd0) begin
                st_q <= 8'h00;
                rb_valid_q <= 1'b0;
                if (ctype_q != `SCCU_CT_INC && ctype_q != `SCCU_CT_REQ) begin
                    st_q[`SCCU_ST_SIG] <= 1'b1;
                end else if (ctype_q == `SCCU_CT_INC && byte_cnt_q != `SCCU_LEN_INC) begin
                    st_q[`SCCU_ST_SIG] <= 1'b1;
                end else if (ctype_q == `SCCU_CT_REQ && byte_cnt_q != `SCCU_LEN_REQ) begin
                    st_q[`SCCU_ST_SIG] <= 1'b1;
                end else if (rsvd_q != 8'h00 || slot_q >= `SCCU_NUM_SLOTS) begin
                    st_q[`SCCU_ST_SIG] <= 1'b1;
                end else if (!slot_ctr_init[slot2] || !slot_key_loaded[slot2]) begin
                    st_q[`SCCU_ST_UNINIT] <= 1'b1;
                end else begin
                    state_q <= S_SIGN;
                    hmac_start_q <= 1'b1;
                    hmac_slot_q <= slot2;
                    if (ctype_q == `SCCU_CT_INC) begin
                        hmac_msg_q <= {opcode_q, ctype_q, slot_q, rsvd_q, hdata_q, 192'h0};
                        hmac_msg_len_q <= 9'd64;
                    end else begin
                        hmac_msg_q <= {opcode_q, ctype_q, slot_q, rsvd_q, tag_q, 128'h0};
                        hmac_msg_len_q <= 9'd128;
                    end
                    cmd_pending_q <= 1'b0;
                end
            end
            case (state_q)
                S_SIGN: begin
                    if (hmac_done && !cmd_pending_q) begin
                        if (hmac_digest != sig_q) begin
                            st_q[`SCCU_ST_SIG] <= 1'b1;
                            state_q <= S_IDLE;
                        end else if (ctype_q == `SCCU_CT_INC && hdata_q != ctr_cur) begin
                            st_q[`SCCU_ST_MISM] <= 1'b1;
                            state_q <= S_IDLE;
                        end else if (ctype_q == `SCCU_CT_INC) begin
                            ctr_wr_q <= 1'b1;
                            ctr_wr_slot_q <= slot2;
                            ctr_wr_val_q <= ctr_cur + 32'd1;
                            state_q <= S_COMMIT;
                        end else begin
                            hmac_start_q <= 1'b1;
                            hmac_msg_q <= {tag_q, ctr_cur, 128'h0};
                            hmac_msg_len_q <= 9'd128;
                            hdata_q <= ctr_cur;
                            cmd_pending_q <= 1'b1;
                            state_q <= S_RESP;
                        end
                    end
                end
                S_COMMIT: begin
                    if (ctr_wr_done) begin
                        st_q[`SCCU_ST_FATAL] <= ctr_wr_fail;
                        st_q[`SCCU_ST_OK] <= !ctr_wr_fail;
                        state_q <= S_IDLE;
                    end
                end
                S_RESP: begin
                    if (hmac_done) begin
                        st_q[`SCCU_ST_OK] <= 1'b1;
                        rb_valid_q <= 1'b1;
                        sig_q <= hmac_digest;
                        state_q <= S_IDLE;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------
    // readback transmit
    // ----------------------------------------
    // status snapshot taken at the sixteenth rising clock edge so a byte never changes mid-shift
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rb_q <= 392'h0;
            tx_bit_q <= 9'd0;
            tx_en_q <= 1'b0;
            spi_do_q <= 1'b0;
        end else if (frame_start || frame_end) begin
            tx_bit_q <= 9'd0;
            tx_en_q <= 1'b0;
            spi_do_q <= 1'b0;
        end else begin
            if (rise) begin
                tx_bit_q <= tx_bit_q + 9'd1;
                if (tx_bit_q == 9'd15 && opcode_q == `SCCU_OP_READBACK
                        && rec_cnt_q == 14'd0) begin
                    tx_en_q <= 1'b1;
                    rb_q <= rb_valid_q ? {status, tag_q, hdata_q, sig_q}
                                       : {status, 384'h0};
                end
            end
            if (fall && tx_en_q) begin
                spi_do_q <= rb_q[391];
                if (busy) begin
                    rb_q <= {rb_q[390:384], rb_q[391], 384'h0};
                end else begin
                    rb_q <= {rb_q[390:0], 1'b0};
                end
            end
        end
    end
endmodule // sccu_top

// ---- test/sccu_top_monitor.sv ----
`timescale 1ns/100ps
module sccu_top_monitor #(
    parameter TRST_CYC = 7500
) (
    // clock and reset
    input wire core_clk,
    input wire rstn,
    // spi pins
    input wire spi_cs_n,
    input wire spi_do_oe,
    // store and engines
    input wire [127:0] slot_ctr_flat,
    input wire hmac_start_q,
    input wire [1:0] hmac_slot_q,
    input wire [255:0] hmac_msg_q,
    input wire [8:0] hmac_msg_len_q,
    input wire ctr_wr_q,
    input wire [1:0] ctr_wr_slot_q,
    input wire [31:0] ctr_wr_val_q,
    // status
    input wire [7:0] status,
    input wire reset_recovery
);
    reg [31:0] rec_cnt_q;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // ----
    // recovery length counter
    // ----
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn)
            rec_cnt_q <= 32'h0000_0000;
        else
            rec_cnt_q <= reset_recovery ? rec_cnt_q + 32'h0000_0001 : 32'h0000_0000;
    end
    ok_alone_a: assert property (status[7] |-> status[6:0] == 7'h00)
        else $error("ok flag with other status bits");
    ok_after_busy_a: assert property ($rose(status[7]) |-> $past(status[0]) || $past(status[0], 2))
        else $error("ok flag without busy phase");
    start_busy_a: assert property (hmac_start_q |-> status[0] ##1 !hmac_start_q)
        else $error("engine start outside busy or too long");
    inc_msg_a: assert property (hmac_start_q && hmac_msg_q[255:240] == 16'h9b02
        |-> hmac_msg_len_q == 9'h040 && hmac_msg_q[231:224] == 8'h00)
        else $error("increment message malformed");
    resp_msg_a: assert property (hmac_start_q && hmac_msg_len_q == 9'h080
        && hmac_msg_q[255:240] != 16'h9b03
        |-> hmac_msg_q[159:128] == slot_ctr_flat[hmac_slot_q * 32 +: 32])
        else $error("response message lacks stored counter");
    commit_val_a: assert property (ctr_wr_q |-> status[0]
        && ctr_wr_val_q == slot_ctr_flat[ctr_wr_slot_q * 32 +: 32] + 32'h0000_0001)
        else $error("commit value is not stored plus one");
    commit_once_a: assert property (ctr_wr_q |=> !ctr_wr_q [*8])
        else $error("repeated counter commit");
    recovery_clear_a: assert property (reset_recovery |-> status == 8'h00)
        else $error("status not cleared in recovery");
    recovery_len_a: assert property ($fell(reset_recovery) |-> rec_cnt_q == TRST_CYC)
        else $error("recovery length wrong");
    idle_quiet_a: assert property (spi_cs_n [*8] |-> !spi_do_oe)
        else $error("output driven while deselected");
endmodule // sccu_top_monitor

bind sccu_top sccu_top_monitor #(.TRST_CYC(TRST_CYC)) u_mon (
    .core_clk(core_clk), .rstn(rstn), .spi_cs_n(spi_cs_n), .spi_do_oe(spi_do_oe),
    .slot_ctr_flat(slot_ctr_flat), .hmac_start_q(hmac_start_q), .hmac_slot_q(hmac_slot_q),
    .hmac_msg_q(hmac_msg_q), .hmac_msg_len_q(hmac_msg_len_q), .ctr_wr_q(ctr_wr_q),
    .ctr_wr_slot_q(ctr_wr_slot_q), .ctr_wr_val_q(ctr_wr_val_q), .status(status),
    .reset_recovery(reset_recovery)
);

// ---- test/sccu_spi_host.sv ----
`timescale 1ns/100ps
module sccu_spi_host (
    // spi pins
    output reg spi_clk,
    output reg spi_cs_n,
    output reg spi_di,
    input wire spi_do
);
    reg [7:0] tx [0:63];
    reg [7:0] rx [0:63];
    integer rb_cnt = 0;
    initial begin
        spi_clk = 1'b0;
        spi_cs_n = 1'b1;
        spi_di = 1'b0;
    end
    // ----
    // one frame
    // ----
    // eight clocks per byte, msb first
    task xfer(input integer n, input reg pol);
        integer i;
        integer b;
        begin
            // clock reaches idle level before select, never with it
            spi_clk = pol;
            #16;
            spi_cs_n = 1'b0;
            #16;
            for (i = 0; i < n * 8; i = i + 1) begin
                b = 7 - i % 8;
                spi_clk = 1'b0;
                spi_di = tx[i / 8][b];
                #16;
                spi_clk = 1'b1;
                rx[i / 8][b] = spi_do;
                #16;
            end
            spi_clk = pol;
            #8;
            spi_cs_n = 1'b1;
            // released line flips so a stale bit is never read
            spi_di = ~spi_di;
            if (tx[0] == 8'h96)
                rb_cnt = rb_cnt + 1;
        end
    endtask
endmodule // sccu_spi_host

// ---- test/sccu_top_tb.sv ----
`timescale 1ns/100ps
`include "sccu_defs.vh"
`define CHK(a, b) begin \
    checks_done = checks_done + 1; \
    if ((a) !== (b)) begin \
        errors = errors + 1; \
        $display("mismatch at %0t got %h exp %h", $time, (a), (b)); \
    end \
end
module sccu_top_tb;
    localparam [255:0] SIG = {8{32'h5a5a_c3c3}};
    reg core_clk = 1'b0;
    reg rstn = 1'b0;
    reg [127:0] slot_ctr_flat = 128'h0;
    reg hmac_done = 1'b0;
    reg ctr_wr_done = 1'b0;
    reg pol = 1'b0;
    reg slow = 1'b0;
    reg [31:0] rs = 32'h0000_ca7a;
    reg [31:0] c0, c1;
    reg [95:0] tag;
    reg [383:0] fld;
    reg [7:0] e, ty;
    reg [7:0] exp_q [$];
    integer errors = 0;
    integer checks_done = 0;
    integer i;
    wire spi_clk, spi_cs_n, spi_di, spi_do_q, spi_do_oe, hmac_start_q, ctr_wr_q, reset_recovery;
    wire [1:0] hmac_slot_q, ctr_wr_slot_q;
    wire [255:0] hmac_msg_q;
    wire [8:0] hmac_msg_len_q;
    wire [31:0] ctr_wr_val_q;
    wire [7:0] status;
    sccu_top #(.TRST_CYC(200)) u_dut (
        .core_clk(core_clk), .rstn(rstn), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
        .spi_di(spi_di), .spi_do_q(spi_do_q), .spi_do_oe(spi_do_oe),
        .slot_ctr_init(4'hb), .slot_key_loaded(4'h7), .slot_ctr_flat(slot_ctr_flat),
        .hmac_start_q(hmac_start_q), .hmac_slot_q(hmac_slot_q), .hmac_msg_q(hmac_msg_q),
        .hmac_msg_len_q(hmac_msg_len_q), .hmac_done(hmac_done), .hmac_digest(SIG),
        .ctr_wr_q(ctr_wr_q), .ctr_wr_slot_q(ctr_wr_slot_q), .ctr_wr_val_q(ctr_wr_val_q),
        .ctr_wr_done(ctr_wr_done), .ctr_wr_fail(1'b0), .status(status),
        .reset_recovery(reset_recovery)
    );
    sccu_spi_host u_host (.spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_di(spi_di), .spi_do(spi_do_q));
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    function [31:0] xs(input [31:0] v);
        reg [31:0] t;
        begin
            t = v ^ (v << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    // ----
    // tasks
    // ----
    task cyc(input integer n);
        begin
            repeat (n) @(posedge core_clk);
            #1;
        end
    endtask
    task wrap_up;
        begin
            $display("checks %0d mismatches %0d", checks_done, errors);
            if (errors == 0 && checks_done > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    // wait for idle before next command
    task wt;
        integer j;
        begin
            for (j = 0; j < 4000 && (status[0] | reset_recovery) === 1'b1; j = j + 1)
                cyc(1);
            if (j == 4000) begin
                errors = errors + 1;
                wrap_up;
            end
        end
    endtask
    task rb(input integer n, input [7:0] st);
        integer j;
        begin
            exp_q.push_back(st);
            u_host.tx[0] = `SCCU_OP_READBACK;
            for (j = 1; j < 64; j = j + 1)
                u_host.tx[j] = 8'h00;
            u_host.xfer(n, pol);
            cyc(4);
            $display("test step done at %0t", $time);
        end
    endtask
    task sg(input [7:0] t, input [7:0] sl, input [351:0] p, input integer n, input [7:0] st);
        integer j;
        begin
            u_host.tx[0] = `SCCU_OP_SIGNED;
            u_host.tx[1] = t;
            u_host.tx[2] = sl;
            u_host.tx[3] = 8'h00;
            for (j = 0; j < 44; j = j + 1)
                u_host.tx[4 + j] = p[351 - 8 * j -: 8];
            u_host.xfer(n, pol);
            cyc(16);
            if (!slow) begin
                wt;
                rb(3, st);
            end
        end
    endtask
    task one(input [7:0] b);
        begin
            u_host.tx[0] = b;
            u_host.xfer(1, pol);
            cyc(12);
        end
    endtask
    // ----
    // engine, store and result watcher
    // ----
    always @(posedge core_clk) begin
        if (hmac_start_q === 1'b1) begin
            repeat (slow ? 600 : 20) @(posedge core_clk);
            #1 hmac_done = 1'b1;
            @(posedge core_clk);
            #1 hmac_done = 1'b0;
        end
    end
    always @(posedge core_clk) begin
        if (ctr_wr_q === 1'b1) begin
            `CHK(ctr_wr_slot_q, 2'h1)
            `CHK(ctr_wr_val_q, slot_ctr_flat[63:32] + 32'h0000_0001)
            repeat (5) @(posedge core_clk);
            #1 slot_ctr_flat[63:32] = ctr_wr_val_q;
            ctr_wr_done = 1'b1;
            @(posedge core_clk);
            #1 ctr_wr_done = 1'b0;
        end
    end
    always @(u_host.rb_cnt) begin
        e = exp_q.pop_front();
        `CHK(u_host.rx[2], e)
    end
    initial begin
        cyc(10);
        rstn = 1'b1;
        rs = xs(rs);
        c0 = rs;
        rs = xs(rs);
        c1 = rs;
        rs = xs(rs);
        tag = {rs, xs(rs), ~rs};
        slot_ctr_flat = {64'h0, c1, c0};
        cyc(4);
        pol = 1'b1;
        sg(8'h02, 8'h01, {c1, SIG, 64'h0}, 40, 8'h80);
        pol = 1'b0;
        sg(8'h02, 8'h01, {c1, SIG, 64'h0}, 40, 8'h10);
        sg(8'h02, 8'h01, {c1 + 32'h0000_0001, ~SIG, 64'h0}, 40, 8'h04);
        sg(8'h02, 8'h01, {c1 + 32'h0000_0001, SIG, 64'h0}, 39, 8'h04);
        sg(8'h02, 8'h05, {c1, SIG, 64'h0}, 40, 8'h04);
        sg(8'h02, 8'h02, {32'h0, SIG, 64'h0}, 40, 8'h08);
        sg(8'h03, 8'h03, {tag, SIG}, 48, 8'h08);
        for (i = 0; i < 3; i = i + 1) begin
            ty = (i == 0) ? 8'h04 : (i == 1) ? 8'hff : 8'h7e;
            sg(ty, 8'h00, {tag, SIG}, 48, 8'h04);
        end
        sg(8'h03, 8'h00, {tag, SIG}, 47, 8'h04);
        sg(8'h03, 8'h00, {tag, SIG}, 48, 8'h80);
        rb(51, 8'h80);
        fld = {tag, c0, SIG};
        for (i = 0; i < 48; i = i + 1) begin
            `CHK(u_host.rx[3 + i], fld[383 - 8 * i -: 8])
        end
        slow = 1'b1;
        sg(8'h02, 8'h01, {c1 + 32'h0000_0001, SIG, 64'h0}, 40, 8'h00);
        rb(5, 8'h01);
        `CHK(u_host.rx[3], 8'h01)
        `CHK(u_host.rx[4], 8'h01)
        slow = 1'b0;
        wt;
        rb(3, 8'h80);
        pol = 1'b1;
        one(`SCCU_OP_RST_EN);
        rb(3, 8'h80);
        one(`SCCU_OP_RST);
        `CHK(reset_recovery, 1'b0)
        one(`SCCU_OP_RST_EN);
        one(`SCCU_OP_RST);
        `CHK(reset_recovery, 1'b1)
        `CHK(status, 8'h00)
        one(`SCCU_OP_RST_EN);
        wt;
        one(`SCCU_OP_RST);
        `CHK(reset_recovery, 1'b0)
        rb(3, 8'h00);
        cyc(20);
        wrap_up;
    end
endmodule // sccu_top_tb
